//--- src/ictm_core.sv
// instruction timing engine: looks up counts, then paces bus cycles
// Functional notes
// - bit set/invert register: 8 or 12 clocks
// - bit clear: 10 or 14 clocks
// - bit test never writes
// - register bit figures, except static test, are ceilings only
// - address cost added to each memory bit op figure
// - conditional branch: 10 taken, 6/10 not
// - branch 10 clocks, subroutine branch 18
// - decrement-branch 10, expiry 16 clocks
// - jump 8, subroutine jump 16 clocks
// - load address 4, push address 12
// - multi-register move 12+4n / 8+4n clocks
// - alternate-space move 18, long 22
// - index size never changes the count
// - multiprecision counts include fetch and store
// - extended add/subtract 4/6 or 18/30
// - extended loop mode 22, 28, 26
// - memory compare never writes
// - decimal ops 6, 18; loop 24/30/28
`timescale 1ns/1ps
`include "ictm_regs.svh"
module ictm_core #(
	parameter int PROC_DIV = `ICTM_PROC_DIV
) (
	input  logic                 ref_clk,
	input  logic                 rst_n,
	input  logic                 req_valid,
	input  ictm_pkg::ictm_req_t  req,
	input  ictm_pkg::ictm_cost_t ea,
	input  logic                 bus_ack_pin,
	output logic                 req_ready,
	output logic                 bus_req,
	output logic                 bus_write,
	output logic                 done,
	output logic                 illegal,
	output logic                 count_is_max,
	output ictm_pkg::ictm_cost_t total,
	output logic [11:0]          elapsed
);
	import ictm_pkg::*;
	localparam logic [2:0] BUS_LAST = 3'(`ICTM_BUS_CLK - 1);

	ictm_state_t state;
	ictm_state_t next_state;
	ictm_cost_t  tbl;
	ictm_cost_t  next_total;
	logic        tbl_bad;
	logic        tbl_max;
	logic [7:0]  div;
	logic [7:0]  next_div;
	logic        tick;
	logic        ack_s1;
	logic        ack_s2;
	logic        take;
	logic        cyc_end;
	logic [5:0]  rd_left;
	logic [5:0]  next_rd;
	logic [5:0]  wr_left;
	logic [5:0]  next_wr;
	logic [5:0]  left;
	logic [9:0]  core_left;
	logic [9:0]  next_core;
	logic [9:0]  bus_clk;
	logic [2:0]  cyc;
	logic [2:0]  next_cyc;
	logic [11:0] next_el;
	logic        next_ill;
	logic        next_max;
	logic        next_ready;
	logic        next_bus_req;
	logic        next_bus_wr;
	logic        next_done;

	ictm_table u_table (
		.req    (req),
		.ea     (ea),
		.cost   (tbl),
		.bad    (tbl_bad),
		.is_max (tbl_max)
	);

	// processor clock as an enable; the core never sees a second clock
	always_comb begin
		tick = (div == 8'(PROC_DIV - 1));
		next_div = tick ? 8'h00 : div + 8'h01;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div <= 8'h00;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			div <= next_div;
			ack_s1 <= bus_ack_pin;
			ack_s2 <= ack_s1;
		end
	end

	assign take = req_valid && req_ready;

	always_comb begin
		next_state = state;
		next_total = total;
		next_ill = illegal;
		next_max = count_is_max;
		next_rd = rd_left;
		next_wr = wr_left;
		next_core = core_left;
		next_cyc = cyc;
		next_el = elapsed;
		cyc_end = 1'b0;
		left = (state == st_read) ? rd_left : wr_left;
		bus_clk = (10'(tbl.rd) + 10'(tbl.wr)) * 10'(`ICTM_BUS_CLK);
		case (state)
		st_idle: begin
			if (take) begin
				next_total = tbl;
				next_ill = tbl_bad;
				next_max = tbl_max;
				next_el = 12'h000;
				next_rd = tbl.rd;
				next_wr = tbl.wr;
				next_cyc = 3'h0;
				// clocks left once every bus cycle had its share
				next_core = (tbl.clk > bus_clk) ?
					tbl.clk - bus_clk : 10'h000;
				next_state = tbl_bad ? st_done : st_read;
			end
		end
		st_read, st_write: begin
			if (left == 6'h00)
				next_state = (state == st_read) ? st_core : st_done;
			// the gap between cycles is no bus clock: the partner
			// cannot answer a request that is not yet raised
			else if (tick && bus_req) begin
				next_el = elapsed + 12'h001;
				// a cycle ends only on its last clock with ack seen
				if (cyc != BUS_LAST)
					next_cyc = cyc + 3'h1;
				else if (ack_s2) begin
					cyc_end = 1'b1;
					next_cyc = 3'h0;
					if (state == st_read)
						next_rd = rd_left - 6'h01;
					else
						next_wr = wr_left - 6'h01;
				end
			end
		end
		st_core: begin
			if (core_left == 10'h000)
				next_state = st_write;
			else if (tick) begin
				next_core = core_left - 10'h001;
				next_el = elapsed + 12'h001;
			end
		end
		st_done: next_state = st_idle;
		default: next_state = st_idle;
		endcase
		next_ready = (next_state == st_idle);
		next_done = (next_state == st_done);
		// strobe drops for one clock between cycles to mark the boundary
		next_bus_req = !cyc_end &&
			((next_state == st_read && next_rd != 6'h00) ||
			(next_state == st_write && next_wr != 6'h00));
		next_bus_wr = (next_state == st_write);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= st_idle;
			total <= '0;
			illegal <= 1'b0;
			count_is_max <= 1'b0;
			rd_left <= 6'h00;
			wr_left <= 6'h00;
			core_left <= 10'h000;
			cyc <= 3'h0;
			elapsed <= 12'h000;
			req_ready <= 1'b0;
			bus_req <= 1'b0;
			bus_write <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			total <= next_total;
			illegal <= next_ill;
			count_is_max <= next_max;
			rd_left <= next_rd;
			wr_left <= next_wr;
			core_left <= next_core;
			cyc <= next_cyc;
			elapsed <= next_el;
			req_ready <= next_ready;
			bus_req <= next_bus_req;
			bus_write <= next_bus_wr;
			done <= next_done;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_bit_set_reg: assert property (
		take && req.op inside {bit_set_op, bit_invert_op} &&
		!req.to_mem && req.is_static |=>
		total.clk == 10'h00C && total.rd == 6'h02 && count_is_max)
		else $error("static register bit set count wrong");

	a_bit_clear_reg: assert property (
		take && req.op == bit_clear_op && !req.to_mem &&
		!req.is_static |=> total.clk == 10'h00A && total.rd == 6'h01)
		else $error("dynamic register bit clear count wrong");

	a_bit_test_nowr: assert property (
		take && req.op == bit_test_op |=> total.wr == 6'h00)
		else $error("bit test counted a write");

	a_ea_added: assert property (
		take && req.op == bit_test_op && req.to_mem &&
		!req.is_static |=>
		total.clk == 10'($past(ea.clk) + 10'h004) &&
		total.rd == 6'($past(ea.rd) + 6'h01))
		else $error("address cost not added");

	a_branch_short: assert property (
		take && req.op == cond_branch && !req.cond &&
		!req.disp_word |=> total.clk == 10'h006 && total.rd == 6'h01)
		else $error("short untaken branch count wrong");

	a_subr_branch: assert property (
		take && req.op == branch_to_subroutine |=>
		total.clk == 10'h012 && total.wr == 6'h02)
		else $error("subroutine branch count wrong");

	a_dec_expire: assert property (
		take && req.op == decrement_and_branch && !req.cond &&
		req.loop == lp_expired |=>
		total.clk == 10'h010 && total.rd == 6'h03)
		else $error("expired loop count wrong");

	a_jump_areg: assert property (
		take && req.op == jump_op && req.mode == m_ind |=>
		total.clk == 10'h008 && total.rd == 6'h02)
		else $error("register jump count wrong");

	a_lea_areg: assert property (
		take && req.op == load_effective_address &&
		req.mode == m_ind |=> total.clk == 10'h004)
		else $error("load address count wrong");

	a_multi_register_move_load: assert property (
		take && req.op == multi_register_move && !req.to_mem &&
		!req.is_long && req.mode == m_ind |=>
		total.clk == 10'(10'h00C + 10'h004 * $past(req.nregs)))
		else $error("register load count wrong");

	a_xadd_loop: assert property (
		take && req.op == extended_add && req.to_mem &&
		!req.is_long && req.loop == lp_cont |=> total.clk == 10'h016)
		else $error("extended loop count wrong");

	sequence s_cycle_wait;
		bus_req && !ack_s2;
	endsequence

	sequence s_cycle_held;
		bus_req;
	endsequence

	a_wait_holds: assert property (
		s_cycle_wait |=> s_cycle_held)
		else $error("bus cycle ended without acknowledge");

	a_done_length: assert property (
		done && !illegal |-> elapsed >= 12'(total.clk))
		else $error("execution shorter than counted");

	a_max_flag: assert property (
		take && !(req.op inside {bit_invert_op, bit_clear_op,
		bit_set_op, bit_test_op}) |=> !count_is_max)
		else $error("ceiling flagged outside bit operations");

	a_alternate_space_move_areg: assert property (
		take && req.op == alternate_space_move && req.mode == m_ind &&
		!req.is_long |=> total.clk == 10'h012)
		else $error("alternate-space move count wrong");

	a_xadd_mem: assert property (
		take && req.op inside {extended_add, extended_subtract} &&
		req.to_mem && req.is_long && req.loop == lp_none |=>
		total.clk == 10'h01E && total.wr == 6'h02)
		else $error("long memory extended count wrong");

	a_memory_compare_nowr: assert property (
		take && req.op == memory_compare |=> total.wr == 6'h00)
		else $error("memory compare counted a write");

	a_bcd_loop: assert property (
		take && req.op inside {decimal_add, decimal_subtract} &&
		req.to_mem && !req.is_long && req.loop == lp_cond |=>
		total.clk == 10'h01E)
		else $error("decimal loop count wrong");
endmodule // ictm_core

//--- src/ictm_pkg.sv
// types of the instruction timing block
package ictm_pkg;
	typedef enum logic [4:0] {
		bit_invert_op, bit_clear_op, bit_set_op, bit_test_op,
		cond_branch, unconditional_branch, branch_to_subroutine,
		decrement_and_branch, jump_op, subroutine_jump,
		load_effective_address, push_effective_address,
		multi_register_move, alternate_space_move, extended_add,
		extended_subtract, memory_compare, decimal_add,
		decimal_subtract
	} ictm_op_t;
	typedef enum logic [3:0] {
		m_ind, m_postinc, m_predec, m_d16, m_idx,
		m_absw, m_absl, m_d16pc, m_idxpc
	} ictm_mode_t;
	typedef enum logic [1:0] {
		lp_none, lp_cont, lp_cond, lp_expired
	} ictm_loop_t;
	typedef struct packed {
		ictm_op_t   op;
		ictm_mode_t mode;
		logic       is_long;
		logic       is_static;
		logic       to_mem;
		logic       cond;
		logic       disp_word;
		ictm_loop_t loop;
		logic [4:0] nregs;
	} ictm_req_t;
	typedef struct packed {
		logic [9:0] clk;
		logic [5:0] rd;
		logic [5:0] wr;
	} ictm_cost_t;
	typedef enum logic [2:0] {
		st_idle  = 3'h0,
		st_read  = 3'h1,
		st_core  = 3'h3,
		st_write = 3'h2,
		st_done  = 3'h6
	} ictm_state_t;
endpackage

//--- src/ictm_regs.svh
// cycle-count constants of the instruction timing block
`ifndef ICTM_REGS_SVH
`define ICTM_REGS_SVH
`define ICTM_BUS_CLK 4
`define ICTM_PROC_DIV 1
// per addressing mode, index 8 down to 0:
// idxpc, d16pc, absl, absw, idx, d16, predec, postinc, ind
`define ICTM_JMP_C {8'h0E,8'h0A,8'h0C,8'h0A,8'h0E,8'h0A,8'h00,8'h00,8'h08}
`define ICTM_JMP_R {4'h3,4'h2,4'h3,4'h2,4'h3,4'h2,4'h0,4'h0,4'h2}
`define ICTM_JSR_C {8'h16,8'h12,8'h14,8'h12,8'h16,8'h12,8'h00,8'h00,8'h10}
`define ICTM_JSR_R {4'h2,4'h2,4'h3,4'h2,4'h2,4'h2,4'h0,4'h0,4'h2}
`define ICTM_LEA_C {8'h0C,8'h08,8'h0C,8'h08,8'h0C,8'h08,8'h00,8'h00,8'h04}
`define ICTM_PEA_C {8'h14,8'h10,8'h14,8'h10,8'h14,8'h10,8'h00,8'h00,8'h0C}
`define ICTM_LEA_R {4'h2,4'h2,4'h3,4'h2,4'h2,4'h2,4'h0,4'h0,4'h1}
`define ICTM_MMR_C {8'h12,8'h10,8'h14,8'h10,8'h12,8'h10,8'h00,8'h0C,8'h0C}
`define ICTM_MMR_R {4'h4,4'h4,4'h5,4'h4,4'h4,4'h4,4'h0,4'h3,4'h3}
`define ICTM_MRM_C {8'h00,8'h00,8'h10,8'h0C,8'h0E,8'h0C,8'h08,8'h00,8'h08}
`define ICTM_MRM_R {4'h0,4'h0,4'h4,4'h3,4'h3,4'h3,4'h2,4'h0,4'h2}
`define ICTM_MS_C {8'h00,8'h00,8'h18,8'h14,8'h18,8'h14,8'h14,8'h14,8'h12}
`define ICTM_MSR_R {4'h0,4'h0,4'h5,4'h4,4'h4,4'h4,4'h3,4'h3,4'h3}
`define ICTM_MSW_R {4'h0,4'h0,4'h4,4'h3,4'h3,4'h3,4'h2,4'h2,4'h2}
// bit ops, index {static, memory}
`define ICTM_BS_C {8'h0C,8'h0C,8'h08,8'h08}
`define ICTM_BC_C {8'h0E,8'h0E,8'h0A,8'h0A}
`define ICTM_BT_C {8'h08,8'h0A,8'h04,8'h06}
`define ICTM_BI_R {4'h2,4'h2,4'h1,4'h1}
`define ICTM_BI_W {4'h1,4'h0,4'h1,4'h0}
// multiprecision, index: expired, cond, continued, memory, register
`define ICTM_XB_C {8'h1A,8'h1C,8'h16,8'h12,8'h04}
`define ICTM_XB_R {4'h4,4'h4,4'h2,4'h3,4'h1}
`define ICTM_XB_W {4'h1,4'h1,4'h1,4'h1,4'h0}
`define ICTM_XL_C {8'h24,8'h26,8'h20,8'h1E,8'h06}
`define ICTM_XL_R {4'h6,4'h6,4'h4,4'h5,4'h1}
`define ICTM_XL_W {4'h2,4'h2,4'h2,4'h2,4'h0}
`define ICTM_CB_C {8'h12,8'h14,8'h0E,8'h0C,8'h00}
`define ICTM_CB_R {4'h4,4'h4,4'h2,4'h3,4'h0}
`define ICTM_CL_C {8'h1A,8'h1E,8'h18,8'h14,8'h00}
`define ICTM_CL_R {4'h6,4'h6,4'h4,4'h5,4'h0}
`define ICTM_BCD_C {8'h1C,8'h1E,8'h18,8'h12,8'h06}
`define ICTM_BR_C 8'h0A
`define ICTM_BR_R 4'h2
`define ICTM_BRS_C 8'h06
`define ICTM_BRS_R 4'h1
`define ICTM_BSR_C 8'h12
`define ICTM_PUSH_W 4'h2
`define ICTM_DBX_C 8'h10
`define ICTM_DBX_R 4'h3
`define ICTM_MM_W 8'h04
`define ICTM_MM_L 8'h08
`define ICTM_MS_L 8'h04
`endif

//--- src/ictm_table.sv
// cycle-count lookup: base figures plus address cost
`timescale 1ns/1ps
`include "ictm_regs.svh"
module ictm_table (
	input  ictm_pkg::ictm_req_t  req,
	input  ictm_pkg::ictm_cost_t ea,
	output ictm_pkg::ictm_cost_t cost,
	output logic                 bad,
	output logic                 is_max
);
	import ictm_pkg::*;
	localparam logic [8:0][7:0] JMP_C = `ICTM_JMP_C;
	localparam logic [8:0][3:0] JMP_R = `ICTM_JMP_R;
	localparam logic [8:0][7:0] JSR_C = `ICTM_JSR_C;
	localparam logic [8:0][3:0] JSR_R = `ICTM_JSR_R;
	localparam logic [8:0][7:0] LEA_C = `ICTM_LEA_C;
	localparam logic [8:0][7:0] PEA_C = `ICTM_PEA_C;
	localparam logic [8:0][3:0] LEA_R = `ICTM_LEA_R;
	localparam logic [8:0][7:0] MMR_C = `ICTM_MMR_C;
	localparam logic [8:0][3:0] MMR_R = `ICTM_MMR_R;
	localparam logic [8:0][7:0] MRM_C = `ICTM_MRM_C;
	localparam logic [8:0][3:0] MRM_R = `ICTM_MRM_R;
	localparam logic [8:0][7:0] MS_C  = `ICTM_MS_C;
	localparam logic [8:0][3:0] MSR_R = `ICTM_MSR_R;
	localparam logic [8:0][3:0] MSW_R = `ICTM_MSW_R;
	localparam logic [3:0][7:0] BS_C  = `ICTM_BS_C;
	localparam logic [3:0][7:0] BC_C  = `ICTM_BC_C;
	localparam logic [3:0][7:0] BT_C  = `ICTM_BT_C;
	localparam logic [3:0][3:0] BI_R  = `ICTM_BI_R;
	localparam logic [3:0][3:0] BI_W  = `ICTM_BI_W;
	localparam logic [4:0][7:0] XB_C  = `ICTM_XB_C;
	localparam logic [4:0][3:0] XB_R  = `ICTM_XB_R;
	localparam logic [4:0][3:0] XB_W  = `ICTM_XB_W;
	localparam logic [4:0][7:0] XL_C  = `ICTM_XL_C;
	localparam logic [4:0][3:0] XL_R  = `ICTM_XL_R;
	localparam logic [4:0][3:0] XL_W  = `ICTM_XL_W;
	localparam logic [4:0][7:0] CB_C  = `ICTM_CB_C;
	localparam logic [4:0][3:0] CB_R  = `ICTM_CB_R;
	localparam logic [4:0][7:0] CL_C  = `ICTM_CL_C;
	localparam logic [4:0][3:0] CL_R  = `ICTM_CL_R;
	localparam logic [4:0][7:0] BCD_C = `ICTM_BCD_C;

	logic [1:0] bi;
	logic [3:0] mi;
	logic [2:0] li;
	logic [9:0] c;
	logic [5:0] r;
	logic [5:0] w;
	logic [5:0] n;
	logic       add_ea;

	always_comb begin
		bi = {req.is_static, req.to_mem};
		mi = (req.mode > m_idxpc) ? 4'h0 : req.mode;
		li = req.to_mem ? 3'(req.loop) + 3'h1 : 3'h0;
		n = 6'(req.nregs);
		c = '0;
		r = '0;
		w = '0;
		bad = 1'b0;
		add_ea = req.to_mem;
		// register-operand figures are ceilings, except static test
		is_max = req.op <= bit_test_op && !req.to_mem &&
			!(req.op == bit_test_op && req.is_static);
		case (req.op)
		bit_invert_op, bit_set_op: begin
			c = 10'(BS_C[bi]);
			r = 6'(BI_R[bi]);
			w = 6'(BI_W[bi]);
		end
		bit_clear_op: begin
			c = 10'(BC_C[bi]);
			r = 6'(BI_R[bi]);
			w = 6'(BI_W[bi]);
		end
		bit_test_op: begin
			c = 10'(BT_C[bi]);
			r = 6'(BI_R[bi]);
		end
		cond_branch: begin
			if (req.cond || req.disp_word) begin
				c = 10'(`ICTM_BR_C);
				r = 6'(`ICTM_BR_R);
			end else begin
				c = 10'(`ICTM_BRS_C);
				r = 6'(`ICTM_BRS_R);
			end
		end
		unconditional_branch: begin
			c = 10'(`ICTM_BR_C);
			r = 6'(`ICTM_BR_R);
		end
		branch_to_subroutine: begin
			c = 10'(`ICTM_BSR_C);
			r = 6'(`ICTM_BR_R);
			w = 6'(`ICTM_PUSH_W);
		end
		decrement_and_branch: begin
			if (!req.cond && req.loop == lp_expired) begin
				c = 10'(`ICTM_DBX_C);
				r = 6'(`ICTM_DBX_R);
			end else begin
				c = 10'(`ICTM_BR_C);
				r = 6'(`ICTM_BR_R);
			end
		end
		// index size is not an input: both sizes cost the same
		jump_op: begin
			c = 10'(JMP_C[mi]);
			r = 6'(JMP_R[mi]);
		end
		subroutine_jump: begin
			c = 10'(JSR_C[mi]);
			r = 6'(JSR_R[mi]);
			w = 6'(`ICTM_PUSH_W);
		end
		load_effective_address: begin
			c = 10'(LEA_C[mi]);
			r = 6'(LEA_R[mi]);
		end
		push_effective_address: begin
			c = 10'(PEA_C[mi]);
			r = 6'(LEA_R[mi]);
			w = 6'(`ICTM_PUSH_W);
		end
		multi_register_move: begin
			if (req.to_mem) begin
				c = 10'(MRM_C[mi]);
				r = 6'(MRM_R[mi]);
				w = req.is_long ? n << 1 : n;
			end else begin
				c = 10'(MMR_C[mi]);
				r = 6'(MMR_R[mi]) + (req.is_long ? n << 1 : n);
			end
			if (c != '0)
				c = c + 10'(n) * 10'(req.is_long ?
					`ICTM_MM_L : `ICTM_MM_W);
		end
		alternate_space_move: begin
			c = 10'(MS_C[mi]);
			if (c != '0 && req.is_long)
				c = c + 10'(`ICTM_MS_L);
			if (req.to_mem) begin
				r = 6'(MSW_R[mi]);
				w = req.is_long ? 6'h02 : 6'h01;
			end else
				r = 6'(MSR_R[mi]) + 6'(req.is_long);
		end
		// multiprecision figures already hold fetch, store, prefetch
		extended_add, extended_subtract: begin
			c = 10'(req.is_long ? XL_C[li] : XB_C[li]);
			r = 6'(req.is_long ? XL_R[li] : XB_R[li]);
			w = 6'(req.is_long ? XL_W[li] : XB_W[li]);
		end
		memory_compare: begin
			c = 10'(req.is_long ? CL_C[li] : CB_C[li]);
			r = 6'(req.is_long ? CL_R[li] : CB_R[li]);
		end
		decimal_add, decimal_subtract: begin
			c = 10'(BCD_C[li]);
			r = 6'(XB_R[li]);
			w = 6'(XB_W[li]);
			bad = req.is_long;
		end
		default: bad = 1'b1;
		endcase
		if (req.op > bit_test_op)
			add_ea = 1'b0;
		if (req.op inside {jump_op, subroutine_jump,
			load_effective_address, push_effective_address,
			multi_register_move, alternate_space_move} &&
			req.mode > m_idxpc)
			bad = 1'b1;
		if (c == '0)
			bad = 1'b1;
		// address cost added to each figure on its own
		cost.clk = c + (add_ea ? ea.clk : 10'h000);
		cost.rd = r + (add_ea ? ea.rd : 6'h00);
		cost.wr = w + (add_ea ? ea.wr : 6'h00);
	end
endmodule // ictm_table

//--- verification/ictm_bus_model.sv
// bus partner model: memory that ends each bus cycle after a set delay
`timescale 1ns/1ps
module ictm_bus_model (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       bus_req,
	input  wire logic [3:0] wait_cycles,
	output logic            bus_ack_pin
);
	logic [3:0] held;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			held <= 4'h0;
			bus_ack_pin <= 1'b0;
		end else if (!bus_req) begin
			// ack falls within one clock of the request dropping
			held <= 4'h0;
			bus_ack_pin <= 1'b0;
		end else begin
			if (held != 4'hF) begin
				held <= held + 4'h1;
			end
			// a nonzero delay stands for a slow device inserting waits
			bus_ack_pin <= (held >= wait_cycles);
		end
	end
endmodule // ictm_bus_model

//--- verification/instruction_cycle_timing_test.sv
// self-checking bench of the instruction timing engine
`timescale 1ns/1ps
`define chk(what, exp, got) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("mismatch %s expected %0h seen %0h", what, exp, got); \
	end \
end
module instruction_cycle_timing_test;
	import ictm_pkg::*;
	typedef struct {
		ictm_req_t  q;
		ictm_cost_t ea;
		ictm_cost_t exp;
		logic       mx;
	} ictm_row_t;

	logic        ref_clk;
	logic        rst_n;
	logic        req_valid;
	ictm_req_t   req;
	ictm_cost_t  ea;
	logic        bus_ack_pin;
	logic        req_ready;
	logic        bus_req;
	logic        bus_write;
	logic        done;
	logic        illegal;
	logic        count_is_max;
	ictm_cost_t  total;
	logic [11:0] elapsed;
	logic [3:0]  wait_cycles;
	logic        prev_req;
	logic        prev_wr;
	int          fail_count;
	int          samples_checked;
	int          rd_seen;
	int          wr_seen;
	int          rd_base;
	int          wr_base;
	ictm_cost_t  cur_ea;
	ictm_row_t   rows[$];

	ictm_core #(.PROC_DIV(1)) dut_u (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.req_valid   (req_valid),
		.req         (req),
		.ea          (ea),
		.bus_ack_pin (bus_ack_pin),
		.req_ready   (req_ready),
		.bus_req     (bus_req),
		.bus_write   (bus_write),
		.done        (done),
		.illegal     (illegal),
		.count_is_max(count_is_max),
		.total       (total),
		.elapsed     (elapsed)
	);

	ictm_bus_model bus_u (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.bus_req    (bus_req),
		.wait_cycles(wait_cycles),
		.bus_ack_pin(bus_ack_pin)
	);

	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		ea = '0;
		wait_cycles = 4'h0;
		prev_req = 1'b0;
		prev_wr = 1'b0;
		fail_count = 0;
		samples_checked = 0;
		rd_seen = 0;
		wr_seen = 0;
	end

	always #2.5 ref_clk = ~ref_clk;

	// a bus cycle is counted when its request drops
	always @(negedge ref_clk) begin
		if (prev_req && !bus_req) begin
			if (prev_wr) begin
				wr_seen++;
			end else begin
				rd_seen++;
			end
		end
		prev_req = bus_req;
		prev_wr = bus_write;
	end

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// flags: [7:6] loop, [5] ceiling, [4] long, [3] static, [2] memory,
	// [1] cond, [0] word displacement
	function automatic ictm_req_t mk(input ictm_op_t o, input ictm_mode_t m,
		input logic [7:0] f, input logic [4:0] n);
		mk = '{o, m, f[4], f[3], f[2], f[1], f[0], ictm_loop_t'(f[7:6]), n};
	endfunction

	task automatic row(input ictm_op_t o, input ictm_mode_t m,
		input logic [7:0] f, input logic [4:0] n, input logic [7:0] c,
		input logic [7:0] rw);
		ictm_row_t x;
		x.q = mk(o, m, f, n);
		x.ea = cur_ea;
		x.exp = '{{2'h0, c}, {2'h0, rw[7:4]}, {2'h0, rw[3:0]}};
		x.mx = f[5];
		rows.push_back(x);
	endtask

	task automatic issue(input ictm_req_t q, input ictm_cost_t e);
		int n;
		n = 0;
		@(negedge ref_clk);
		while (req_ready !== 1'b1 && n < 300) begin
			@(negedge ref_clk);
			n++;
		end
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req <= q;
		ea <= e;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		rd_base = rd_seen;
		wr_base = wr_seen;
	endtask

	task automatic wait_done(output int k);
		k = 0;
		do begin
			@(negedge ref_clk);
			k++;
		end while (done !== 1'b1 && k < 400);
	endtask

	task automatic run_row(input ictm_row_t x, input logic slow);
		int k;
		int lo;
		issue(x.q, x.ea);
		wait_done(k);
		lo = x.exp.clk + 2 * (x.exp.rd + x.exp.wr);
		`chk("done", 1'b1, done)
		`chk("illegal", 1'b0, illegal)
		`chk("total", x.exp, total)
		`chk("ceiling", x.mx, count_is_max)
		`chk("reads", x.exp.rd, 6'(rd_seen - rd_base))
		`chk("writes", x.exp.wr, 6'(wr_seen - wr_base))
		if (slow) begin
			`chk("stretched", 1'b1, elapsed > lo && elapsed < 5 * lo)
		end else begin
			`chk("elapsed", {2'h0, x.exp.clk}, elapsed)
		end
	endtask

	initial begin
		int k;
		ictm_req_t bad[4];
		cur_ea = '0;
		row(bit_set_op,m_ind,8'h20,5'h0,8'h08,8'h10);
		row(bit_invert_op,m_ind,8'h28,5'h0,8'h0C,8'h20);
		row(bit_clear_op,m_ind,8'h20,5'h0,8'h0A,8'h10);
		row(bit_clear_op,m_ind,8'h28,5'h0,8'h0E,8'h20);
		row(bit_test_op,m_ind,8'h20,5'h0,8'h06,8'h10);
		row(bit_test_op,m_ind,8'h08,5'h0,8'h0A,8'h20);
		cur_ea = '{10'h004, 6'h01, 6'h00};
		row(bit_clear_op,m_d16,8'h04,5'h0,8'h0E,8'h21);
		row(bit_invert_op,m_d16,8'h0C,5'h0,8'h10,8'h31);
		row(bit_set_op,m_ind,8'h04,5'h0,8'h0C,8'h21);
		cur_ea = '{10'h008, 6'h02, 6'h00};
		row(bit_test_op,m_absl,8'h0C,5'h0,8'h10,8'h40);
		row(bit_test_op,m_idx,8'h04,5'h0,8'h0C,8'h30);
		row(cond_branch,m_ind,8'h02,5'h0,8'h0A,8'h20);
		row(cond_branch,m_ind,8'h00,5'h0,8'h06,8'h10);
		row(cond_branch,m_ind,8'h01,5'h0,8'h0A,8'h20);
		row(unconditional_branch,m_ind,8'h01,5'h0,8'h0A,8'h20);
		row(branch_to_subroutine,m_ind,8'h00,5'h0,8'h12,8'h22);
		row(branch_to_subroutine,m_ind,8'h01,5'h0,8'h12,8'h22);
		row(decrement_and_branch,m_ind,8'h02,5'h0,8'h0A,8'h20);
		row(decrement_and_branch,m_ind,8'hC0,5'h0,8'h10,8'h30);
		row(decrement_and_branch,m_ind,8'h00,5'h0,8'h0A,8'h20);
		row(jump_op,m_ind,8'h00,5'h0,8'h08,8'h20);
		row(jump_op,m_absw,8'h00,5'h0,8'h0A,8'h20);
		row(subroutine_jump,m_d16pc,8'h00,5'h0,8'h12,8'h22);
		row(subroutine_jump,m_ind,8'h00,5'h0,8'h10,8'h22);
		row(subroutine_jump,m_idx,8'h00,5'h0,8'h16,8'h22);
		row(load_effective_address,m_ind,8'h00,5'h0,8'h04,8'h10);
		row(push_effective_address,m_ind,8'h00,5'h0,8'h0C,8'h12);
		row(load_effective_address,m_idx,8'h10,5'h0,8'h0C,8'h20);
		row(push_effective_address,m_idx,8'h10,5'h0,8'h14,8'h22);
		row(load_effective_address,m_idxpc,8'h10,5'h0,8'h0C,8'h20);
		row(multi_register_move,m_ind,8'h00,5'h3,8'h18,8'h60);
		row(multi_register_move,m_ind,8'h04,5'h3,8'h14,8'h23);
		row(multi_register_move,m_ind,8'h14,5'h2,8'h18,8'h24);
		row(multi_register_move,m_postinc,8'h10,5'h2,8'h1C,8'h70);
		row(alternate_space_move,m_ind,8'h00,5'h0,8'h12,8'h30);
		row(alternate_space_move,m_ind,8'h04,5'h0,8'h12,8'h21);
		row(alternate_space_move,m_ind,8'h10,5'h0,8'h16,8'h40);
		row(extended_add,m_predec,8'h00,5'h0,8'h04,8'h10);
		row(extended_subtract,m_predec,8'h10,5'h0,8'h06,8'h10);
		row(extended_add,m_predec,8'h04,5'h0,8'h12,8'h31);
		row(extended_subtract,m_predec,8'h14,5'h0,8'h1E,8'h52);
		row(extended_add,m_predec,8'h44,5'h0,8'h16,8'h21);
		row(extended_subtract,m_predec,8'h84,5'h0,8'h1C,8'h41);
		row(extended_add,m_predec,8'hC4,5'h0,8'h1A,8'h41);
		row(memory_compare,m_postinc,8'h04,5'h0,8'h0C,8'h30);
		row(memory_compare,m_postinc,8'h14,5'h0,8'h14,8'h50);
		row(memory_compare,m_postinc,8'h44,5'h0,8'h0E,8'h20);
		row(memory_compare,m_postinc,8'h84,5'h0,8'h14,8'h40);
		row(memory_compare,m_postinc,8'hC4,5'h0,8'h12,8'h40);
		row(decimal_add,m_predec,8'h00,5'h0,8'h06,8'h10);
		row(decimal_subtract,m_predec,8'h04,5'h0,8'h12,8'h31);
		row(decimal_add,m_predec,8'h44,5'h0,8'h18,8'h21);
		row(decimal_subtract,m_predec,8'h84,5'h0,8'h1E,8'h41);
		row(decimal_add,m_predec,8'hC4,5'h0,8'h1C,8'h41);
		repeat (11) @(posedge ref_clk);
		@(negedge ref_clk);
		`chk("reset ready", 1'b0, req_ready)
		`chk("reset bus", 1'b0, bus_req)
		@(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(negedge ref_clk);
		`chk("ready after reset", 1'b1, req_ready)
		foreach (rows[i]) begin
			run_row(rows[i], 1'b0);
		end
		// a request held up while busy must wait its turn
		issue(mk(bit_test_op, m_ind, 8'h20, 5'h0), '0);
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req <= mk(jump_op, m_ind, 8'h00, 5'h0);
		wait_done(k);
		`chk("first stands", 10'h006, total.clk)
		while (req_ready !== 1'b1 && k < 800) begin
			@(negedge ref_clk);
			k++;
		end
		@(posedge ref_clk);
		req_valid <= 1'b0;
		wait_done(k);
		`chk("second", 22'({10'h008, 6'h02, 6'h00}), total)
		bad[0] = mk(memory_compare, m_postinc, 8'h00, 5'h0);
		bad[1] = mk(jump_op, m_postinc, 8'h00, 5'h0);
		bad[2] = mk(decimal_add, m_predec, 8'h14, 5'h0);
		bad[3] = mk(jump_op, ictm_mode_t'(4'hF), 8'h00, 5'h0);
		foreach (bad[i]) begin
			issue(bad[i], '0);
			wait_done(k);
			`chk("refused", 1'b1, illegal)
			`chk("quick end", 1'b1, k <= 4)
			`chk("no time", 12'h000, elapsed)
			`chk("no cycles", 0, rd_seen + wr_seen - rd_base - wr_base)
		end
		// slow memory, then a reset in the middle of a stretched move
		wait_cycles <= 4'h5;
		row(multi_register_move,m_ind,8'h00,5'h3,8'h18,8'h60);
		run_row(rows[$], 1'b1);
		issue(rows[$].q, rows[$].ea);
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b0;
		@(negedge ref_clk);
		`chk("abort bus", 1'b0, bus_req)
		`chk("abort ready", 1'b0, req_ready)
		`chk("abort time", 12'h000, elapsed)
		repeat (11) @(posedge ref_clk);
		rst_n <= 1'b1;
		wait_cycles <= 4'h0;
		run_row(rows[0], 1'b0);
		end_of_test;
	end

	initial begin
		#100000;
		fail_count++;
		$display("mismatch watchdog expected done seen hang");
		end_of_test;
	end
endmodule // instruction_cycle_timing_test
